// ===== sim/awm_host.sv
// serial master model issuing register requests
`timescale 1ns/10ps
module awm_host (
    input  wire logic          mclk,
    output awm_pkg::awm_req_t  req,
    input  wire logic [15:0]   rdata,
    input  wire logic          rvalid
);
    import awm_pkg::*;
    initial req = '0;
    task automatic wr(input logic [7:0] p, input logic [15:0] d);
        @(posedge mclk) #1 req = '{1'b1, 1'b0, p, {4'h0, d[11:0]}};
        @(posedge mclk) #1 req = '0;
    endtask : wr
    task automatic rd(input logic [7:0] p, output logic [15:0] d);
        @(posedge mclk) #1 req = '{1'b0, 1'b1, p, 16'h0000};
        @(posedge mclk) #1 req = '0;
        d = rvalid ? rdata : 'x;
    endtask : rd
endmodule : awm_host

// ===== sim/awm_monitor.sv
// port assertions of the alert window block
`timescale 1ns/10ps
module awm_monitor (
    // clock and reset
    input wire logic               mclk,
    input wire logic               sys_rst,
    // register access and results
    input wire awm_pkg::awm_req_t  req,
    input wire logic [15:0]        rdata,
    input wire logic               rvalid,
    input wire awm_pkg::awm_conv_t conv,
    input wire logic               alert_under,
    input wire logic               alert_over,
    input wire logic               auto_mode
);
    import awm_pkg::*;
    logic hold_q;
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // shadow of the alert hold bit
    always_ff @(posedge mclk)
        if (sys_rst) hold_q <= 1'b0;
        else if (req.wr && req.ptr == 8'h02) hold_q <= req.wdata[4];
    sequence s_reply; rvalid && rdata[15:12] == 4'h0; endsequence
    a_read_answer: assert property (req.rd |=> s_reply)
        else $error("read not answered");
    a_no_stray: assert property (!req.rd |=> !rvalid)
        else $error("stray read valid");
    a_rdata_held: assert property (!rvalid |-> $stable(rdata))
        else $error("read data moved");
    a_under_cause: assert property ($rose(alert_under) |-> $past(conv.valid))
        else $error("under alert without result");
    a_over_cause: assert property ($rose(alert_over) |-> $past(conv.valid))
        else $error("over alert without result");
    a_under_clear: assert property ($fell(alert_under) |-> $past(conv.valid && !hold_q
        || req.wr && req.ptr == 8'h01 && req.wdata[0])) else $error("under alert lost");
    a_over_clear: assert property ($fell(alert_over) |-> $past(conv.valid && !hold_q
        || req.wr && req.ptr == 8'h01 && req.wdata[1])) else $error("over alert lost");
    a_auto_cause: assert property ($changed(auto_mode) |-> $past(req.wr && req.ptr == 8'h02))
        else $error("auto mode moved alone");
endmodule : awm_monitor
bind awm_alert_window awm_monitor i_mon (.mclk(mclk), .sys_rst(sys_rst), .req(req),
    .rdata(rdata), .rvalid(rvalid), .conv(conv), .alert_under(alert_under),
    .alert_over(alert_over), .auto_mode(auto_mode));

// ===== sim/tb_top.sv
// self-checking bench of the alert window block
`timescale 1ns/10ps
module tb_top;
    import awm_pkg::*;
    logic mclk = 0, sys_rst = 1, au, ao, am, rv;
    logic [15:0] rd, v;
    awm_req_t req;
    awm_conv_t conv = '0;
    int fails = 0, check_count = 0;
    always #2.5 mclk = ~mclk;
    awm_alert_window i_dut (.mclk(mclk), .sys_rst(sys_rst), .req(req), .rdata(rd), .rvalid(rv),
        .conv(conv), .alert_under(au), .alert_over(ao), .auto_mode(am));
    awm_host i_host (.mclk(mclk), .req(req), .rdata(rd), .rvalid(rv));
    task chk(input string n, input logic [15:0] s, e);
        check_count++;
        if (s !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task rchk(input logic [7:0] p, input logic [15:0] e);
        i_host.rd(p, v);
        chk("register", v, e);
    endtask : rchk
    // one result, then both flags
    task cv(input logic [11:0] d, input logic eu, eo);
        @(posedge mclk) #1 conv = '{1'b1, d};
        @(posedge mclk) #1 conv = '0;
        chk("flags", {14'h0, au, ao}, {14'h0, eu, eo});
    endtask : cv
    task end_of_test;
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_of_test
    initial begin
        #100000;
        fails++;
        end_of_test();
    end
    initial begin
        repeat (12) @(posedge mclk);
        #1 sys_rst = 0;
        rchk(8'h03, 16'h0000);
        rchk(8'h04, 16'h0FFF);
        rchk(8'h05, 16'h0000);
        rchk(8'h06, 16'h0FFF);
        rchk(8'h08, 16'h0000);
        i_host.wr(8'h03, 16'h0100);
        i_host.wr(8'h04, 16'h0800);
        i_host.wr(8'h05, 16'h0010);
        rchk(8'h04, 16'h0800);
        rchk(8'h05, 16'h0010);
        cv(12'h0FF, 1, 0);
        rchk(8'h06, 16'h00FF);
        cv(12'h110, 1, 0);
        cv(12'h111, 0, 0);
        cv(12'h801, 0, 1);
        cv(12'h7F0, 0, 1);
        cv(12'h7EF, 0, 0);
        i_host.wr(8'h02, 16'h0030);
        chk("auto", {15'h0, am}, 16'h0001);
        cv(12'h050, 1, 0);
        cv(12'hFFF, 1, 1);
        i_host.wr(8'h01, 16'h0001);
        i_host.wr(8'h06, 16'h0FFF);
        cv(12'h500, 0, 1);
        rchk(8'h06, 16'h0500);
        end_of_test();
    end
endmodule : tb_top

// ===== src/awm_alert_window.sv
// alert window, hysteresis and lowest-result register bank
`timescale 1ns/10ps
`include "awm_cfg.svh"
// Notes on behaviour
// - Bits 15 to 12 of limit, hysteresis and lowest registers read as zero; master writes zeros.
// - The lower limit holds 12 bits, resets to zero, and a result below it raises under-range.
// - The upper limit resets to 0FFFh and a result above it raises over-range.
// - An alert self-clears only once the result is back inside its limit by more than hysteresis.
// - With alert hold set, alerts never self-clear.
// - Each result lower than the stored lowest replaces it, otherwise it is kept.
// - The lowest register resets to 0FFFh and writing 0FFFh restarts tracking.
// - In automatic mode the lowest register updates after each conversion without access.
// - Pointer 03h is the lower limit and 04h the upper limit, both read and write.
// - Pointer 05h is hysteresis and 06h the lowest result, both read and write.
// - Writing a one to an alert flag clears it, with or without alert hold.
// - Automatic conversion runs only while the cycle-time field is non-zero.
// - Over-range clears below high minus hyst; under-range clears above low plus hyst.
module awm_alert_window (
    // clock and reset
    input  wire logic           mclk,
    input  wire logic           sys_rst,
    // register access from the serial engine
    input  wire awm_pkg::awm_req_t  req,
    output logic [15:0]         rdata,
    output logic                rvalid,
    // conversion results
    input  wire awm_pkg::awm_conv_t conv,
    // status
    output logic                alert_under,
    output logic                alert_over,
    output logic                auto_mode
);
    import awm_pkg::*;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    awm_state_t  s_q;
    awm_state_t  s_d;
    logic [12:0] low_plus;
    logic [12:0] high_minus;
    logic        set_u;
    logic        set_o;
    logic        clr_u;
    logic        clr_o;
    logic        hold;

    always_comb begin
        s_d        = s_q;
        hold       = s_q.cfg[`AWM_CFG_HOLD_BIT];
        low_plus   = {1'b0, s_q.low} + {1'b0, s_q.hyst};
        high_minus = {1'b0, s_q.high} - {1'b0, s_q.hyst};
        set_u      = conv.valid && (conv.data < s_q.low);
        set_o      = conv.valid && (conv.data > s_q.high);
        // borrow in high_minus means no result can be below it
        clr_u      = conv.valid && !hold && ({1'b0, conv.data} > low_plus);
        clr_o      = conv.valid && !hold && !high_minus[12]
                     && ({1'b0, conv.data} < high_minus);
        s_d.rvalid = 1'b0;
        if (req.wr) begin
            case (req.ptr)
                `AWM_PTR_STATUS: begin
                    if (req.wdata[`AWM_ST_UNDER_BIT]) begin
                        s_d.under = 1'b0;
                    end
                    if (req.wdata[`AWM_ST_OVER_BIT]) begin
                        s_d.over = 1'b0;
                    end
                end
                `AWM_PTR_CONFIG: s_d.cfg  = {req.wdata[7:2], 1'b0, req.wdata[0]};
                `AWM_PTR_LOW:    s_d.low  = req.wdata[11:0];
                `AWM_PTR_HIGH:   s_d.high = req.wdata[11:0];
                `AWM_PTR_HYST:   s_d.hyst = req.wdata[11:0];
                `AWM_PTR_MIN:    s_d.min  = req.wdata[11:0];
                default: begin
                end
            endcase
        end
        // mode flag follows the config value being written, updating on the same edge as the config register
        s_d.auto_en = (s_d.cfg[`AWM_CFG_CYC_HI:`AWM_CFG_CYC_LO] != 3'h0);
        // hysteresis clear first so a fresh violation wins
        if (clr_u) begin
            s_d.under = 1'b0;
        end
        if (clr_o) begin
            s_d.over = 1'b0;
        end
        // hardware set wins over a software clear in the same cycle
        if (set_u) begin
            s_d.under = 1'b1;
        end
        if (set_o) begin
            s_d.over = 1'b1;
        end
        // tracking beats a simultaneous write only when the result is lower
        if (conv.valid && (conv.data < s_d.min)) begin
            s_d.min = conv.data;
        end
        if (req.rd) begin
            s_d.rvalid = 1'b1;
            case (req.ptr)
                `AWM_PTR_STATUS: s_d.rdata = {14'h0000, s_q.over, s_q.under};
                `AWM_PTR_CONFIG: s_d.rdata = {8'h00, s_q.cfg};
                `AWM_PTR_LOW:    s_d.rdata = {4'h0, s_q.low};
                `AWM_PTR_HIGH:   s_d.rdata = {4'h0, s_q.high};
                `AWM_PTR_HYST:   s_d.rdata = {4'h0, s_q.hyst};
                `AWM_PTR_MIN:    s_d.rdata = {4'h0, s_q.min};
                default:         s_d.rdata = 16'h0000;
            endcase
        end
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s_q.low     <= `AWM_RST_LOW;
            s_q.high    <= `AWM_RST_HIGH;
            s_q.hyst    <= `AWM_RST_HYST;
            s_q.min     <= `AWM_RST_MIN;
            s_q.cfg     <= `AWM_RST_CFG;
            s_q.under   <= 1'b0;
            s_q.over    <= 1'b0;
            s_q.rdata   <= 16'h0000;
            s_q.rvalid  <= 1'b0;
            s_q.auto_en <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata       = s_q.rdata;
    assign rvalid      = s_q.rvalid;
    assign alert_under = s_q.under;
    assign alert_over  = s_q.over;
    assign auto_mode   = s_q.auto_en;
endmodule : awm_alert_window

// ===== src/awm_cfg.svh
// register pointers, reset values and field positions of the alert window block
`ifndef AWM_CFG_SVH
`define AWM_CFG_SVH
`define AWM_PTR_STATUS   8'h01
`define AWM_PTR_CONFIG   8'h02
`define AWM_PTR_LOW      8'h03
`define AWM_PTR_HIGH     8'h04
`define AWM_PTR_HYST     8'h05
`define AWM_PTR_MIN      8'h06
`define AWM_RST_LOW      12'h000
`define AWM_RST_HIGH     12'hFFF
`define AWM_RST_HYST     12'h000
`define AWM_RST_MIN      12'hFFF
`define AWM_RST_CFG      8'h00
`define AWM_CFG_HOLD_BIT 4
`define AWM_CFG_CYC_HI   7
`define AWM_CFG_CYC_LO   5
`define AWM_ST_UNDER_BIT 0
`define AWM_ST_OVER_BIT  1
`endif

// ===== src/awm_pkg.sv
// types of the alert window block
package awm_pkg;
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  ptr;
        logic [15:0] wdata;
    } awm_req_t;

    typedef struct packed {
        logic        valid;
        logic [11:0] data;
    } awm_conv_t;

    typedef struct packed {
        logic [11:0] low;
        logic [11:0] high;
        logic [11:0] hyst;
        logic [11:0] min;
        logic [7:0]  cfg;
        logic        under;
        logic        over;
        logic [15:0] rdata;
        logic        rvalid;
        logic        auto_en;
    } awm_state_t;
endpackage : awm_pkg
